// file: cpu_core_end.sv
`timescale 1ns/10ps
`default_nettype none
module cpu_core_end (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   intc_link_if.core link,
   input wire logic accept_en,
   input wire logic [intc_pkg::PC_W-1:0] cur_pc,
   input wire logic [intc_pkg::SRL_W-1:0] cur_srl,
   input wire logic isr_done,
   input wire logic block_cmd,
   input wire logic [intc_pkg::BLK_W-1:0] block_len,
   output logic isr_entry,
   output logic [intc_pkg::VEC_W-1:0] isr_vector,
   output logic [intc_pkg::LEVEL_W-1:0] isr_level,
   output logic resume_valid,
   output logic [intc_pkg::PC_W-1:0] resume_pc,
   output logic [intc_pkg::SRL_W-1:0] resume_srl
);
   import intc_pkg::*;
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic irq_ack;
      logic [PC_W-1:0] ack_pc;
      logic [SRL_W-1:0] ack_srl;
      logic ret_req;
      logic blk_start;
      logic [BLK_W-1:0] blk_len;
      logic entry;
      logic [VEC_W-1:0] vector;
      logic [LEVEL_W-1:0] level;
      logic resume;
      logic [PC_W-1:0] rpc;
      logic [SRL_W-1:0] rsrl;
   } core_state_t;
   core_state_t q; // registered state
   core_state_t d; // next state
   // ----------------------------------------
   // next state
   // ----------------------------------------
   // pulses last one cycle; a return beats an acceptance in the same cycle
   always_comb begin
      d = q;
      d.irq_ack = 1'b0;
      d.ret_req = 1'b0;
      d.entry = 1'b0;
      d.resume = 1'b0;
      d.blk_start = block_cmd;
      if (block_cmd) d.blk_len = block_len;
      if (isr_done) begin
         d.ret_req = 1'b1; // RULE_15
      end else if (link.irq_valid && accept_en && !q.irq_ack && !q.ret_req) begin
         // guard on q.irq_ack: valid is still high in the ack cycle
         d.irq_ack = 1'b1;
         d.ack_pc = cur_pc;
         d.ack_srl = cur_srl;
         d.entry = 1'b1;
         d.vector = link.irq_vec;
         d.level = link.irq_lvl;
      end
      if (link.ret_valid) begin
         d.resume = 1'b1;
         d.rpc = link.ret_pc;
         d.rsrl = link.ret_srl;
      end
   end
   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end
   assign link.irq_ack = q.irq_ack;
   assign link.ack_pc = q.ack_pc;
   assign link.ack_srl = q.ack_srl;
   assign link.ret_req = q.ret_req;
   assign link.blk_start = q.blk_start;
   assign link.blk_len = q.blk_len;
   assign isr_entry = q.entry;
   assign isr_vector = q.vector;
   assign isr_level = q.level;
   assign resume_valid = q.resume;
   assign resume_pc = q.rpc;
   assign resume_srl = q.rsrl;
endmodule : cpu_core_end
`default_nettype wire

// file: intc_ctrl_end.sv
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// RULE_01 - field 1..7 sets level, 000 disables
// RULE_02 - priority fields reset to level four
// RULE_03 - unimplemented bits read zero, writes ignored
// RULE_04 - pwm4 priority in bits 6-4
// RULE_05 - comparator b priority in bits 14-12
// RULE_06 - adc pair 1 14-12, pair 0 10-8
// RULE_07 - adc pair 3 6-4, pair 2 2-0
// RULE_08 - adc pair 6 priority in bits 2-0
// RULE_09 - status bits 11-8 show cpu level
// RULE_10 - status bits 6-0 show vector minus eight
// RULE_11 - nesting disable stops preemption of service
// RULE_12 - software: priority, clear flag, then enable
// RULE_13 - software may give all one priority
// RULE_14 - flag still set at return refires
// RULE_15 - return restores pc, status byte, level
// RULE_16 - trap flag sticks, trap re-entered meanwhile
// RULE_17 - traps unmaskable, level masks only users
// RULE_18 - timed block masks levels 1-6 only
// RULE_19 - above level, highest wins, lower vector ties
module intc_ctrl_end #(
   parameter int DEPTH = 16 // context stack entries
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   intc_link_if.ctrl link,
   input wire logic [intc_pkg::NUM_USER-1:0] src_event,
   input wire logic [intc_pkg::NUM_TRAP-1:0] trap_event,
   input wire logic [intc_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [intc_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic irq
);
   import intc_pkg::*;
   localparam int SP_W = $clog2(DEPTH + 1);
   localparam logic [SP_W-1:0] SP_FULL = SP_W'(DEPTH);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [NUM_USER-1:0][PRIO_W-1:0] prio; // per-source priority
      logic nest_dis;                        // nesting disable
      logic [NUM_TRAP-1:0] trap_flag;        // sticky trap status
      logic [NUM_USER-1:0] pend;             // pending flags
      logic [NUM_USER-1:0] en;               // source enables
      logic [LEVEL_W-1:0] level;             // current cpu level
      logic [IDX_W-1:0] pend_idx;            // best pending vector minus base
      logic [BLK_W-1:0] blk_cnt;             // timed block countdown
      logic [DEPTH-1:0][STACK_W-1:0] stack;  // saved contexts
      logic [SP_W-1:0] sp;
      logic irq_valid;
      logic [VEC_W-1:0] irq_vec;
      logic [LEVEL_W-1:0] irq_lvl;
      logic ret_valid;
      logic [PC_W-1:0] ret_pc;
      logic [SRL_W-1:0] ret_srl;
      logic [EV_W-1:0] ev_sts;               // sticky event status
      logic [EV_W-1:0] ev_en;                // event enables
      logic irq;
      logic aw_full;
      logic [ADDR_W-1:0] aw_addr;
      logic w_full;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready, wready, bvalid;
      logic [1:0] bresp;
      logic arready, rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } ctrl_state_t;
   ctrl_state_t q; // registered state
   ctrl_state_t d; // next state
   // field write honouring the byte lane that holds it
   function automatic logic [PRIO_W-1:0] fld_wr(input logic [PRIO_W-1:0] old, input logic [31:0] data,
                                                input logic [3:0] strb, input int lsb);
      logic [31:0] sh;
      sh = data >> lsb;
      fld_wr = strb[lsb / 8] ? sh[PRIO_W-1:0] : old;
   endfunction : fld_wr
   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      logic [NUM_USER-1:0] clr_pend;
      logic [NUM_TRAP-1:0] clr_trap;
      logic [EV_W-1:0] clr_ev;
      logic [EV_W-1:0] ev_set;
      logic found;
      logic [LEVEL_W-1:0] best_lvl;
      logic [VEC_W-1:0] best_vec;
      logic user_ok;
      clr_pend = '0;
      clr_trap = '0;
      clr_ev = '0;
      ev_set = '0;
      found = 1'b0;
      best_lvl = q.level;
      best_vec = '0;
      user_ok = 1'b0;
      d = q;
      d.ret_valid = 1'b0;
      // register write: address and data may arrive in either order
      if (awvalid && q.awready) begin
         d.aw_full = 1'b1;
         d.aw_addr = awaddr;
      end
      if (wvalid && q.wready) begin
         d.w_full = 1'b1;
         d.w_data = wdata;
         d.w_strb = wstrb;
      end
      if (q.bvalid && bready) d.bvalid = 1'b0;
      if (q.aw_full && q.w_full && !q.bvalid) begin
         d.aw_full = 1'b0;
         d.w_full = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = RESP_OKAY;
         // only implemented fields are stored; all else is dropped
         case (q.aw_addr) // RULE_03
            OFS_PWM4: d.prio[0] = fld_wr(q.prio[0], q.w_data, q.w_strb, PWM4_LSB); // RULE_04
            OFS_CMP2: d.prio[1] = fld_wr(q.prio[1], q.w_data, q.w_strb, CMP2_LSB); // RULE_05
            OFS_ADC01: begin
               d.prio[2] = fld_wr(q.prio[2], q.w_data, q.w_strb, ADC0_LSB); // RULE_06
               d.prio[3] = fld_wr(q.prio[3], q.w_data, q.w_strb, ADC1_LSB); // RULE_06
            end
            OFS_ADC23: begin
               d.prio[4] = fld_wr(q.prio[4], q.w_data, q.w_strb, ADC2_LSB); // RULE_07
               d.prio[5] = fld_wr(q.prio[5], q.w_data, q.w_strb, ADC3_LSB); // RULE_07
            end
            OFS_ADC6: d.prio[6] = fld_wr(q.prio[6], q.w_data, q.w_strb, ADC6_LSB); // RULE_08
            OFS_STATUS: d.bresp = RESP_OKAY; // read-only, write ignored
            OFS_ICON1: begin
               if (q.w_strb[1]) d.nest_dis = q.w_data[NEST_BIT]; // RULE_11
               if (q.w_strb[0]) clr_trap = q.w_data[NUM_TRAP-1:0]; // RULE_16
            end
            OFS_PEND: if (q.w_strb[0]) clr_pend = q.w_data[NUM_USER-1:0];
            OFS_ENABLE: if (q.w_strb[0]) d.en = q.w_data[NUM_USER-1:0];
            OFS_EV_CLR: if (q.w_strb[0]) clr_ev = q.w_data[EV_W-1:0];
            OFS_EV_EN: if (q.w_strb[0]) d.ev_en = q.w_data[EV_W-1:0];
            default: d.bresp = RESP_SLVERR; // unmapped
         endcase
      end
      // register read: one outstanding at a time
      if (q.rvalid && rready) d.rvalid = 1'b0;
      if (arvalid && q.arready) begin
         d.rvalid = 1'b1;
         d.rresp = RESP_OKAY;
         d.rdata = '0; // RULE_03
         case (araddr)
            OFS_PWM4: d.rdata[PWM4_LSB +: PRIO_W] = q.prio[0];
            OFS_CMP2: d.rdata[CMP2_LSB +: PRIO_W] = q.prio[1];
            OFS_ADC01: begin
               d.rdata[ADC0_LSB +: PRIO_W] = q.prio[2];
               d.rdata[ADC1_LSB +: PRIO_W] = q.prio[3];
            end
            OFS_ADC23: begin
               d.rdata[ADC2_LSB +: PRIO_W] = q.prio[4];
               d.rdata[ADC3_LSB +: PRIO_W] = q.prio[5];
            end
            OFS_ADC6: d.rdata[ADC6_LSB +: PRIO_W] = q.prio[6];
            OFS_STATUS: begin
               d.rdata[LEVEL_LSB +: LEVEL_W] = q.level; // RULE_09
               d.rdata[IDX_W-1:0] = q.pend_idx; // RULE_10
            end
            OFS_ICON1: begin
               d.rdata[NEST_BIT] = q.nest_dis;
               d.rdata[NUM_TRAP-1:0] = q.trap_flag;
            end
            OFS_PEND: d.rdata[NUM_USER-1:0] = q.pend;
            OFS_ENABLE: d.rdata[NUM_USER-1:0] = q.en;
            OFS_EV_STS: d.rdata[EV_W-1:0] = q.ev_sts;
            OFS_EV_CLR: d.rdata = '0; // write-only
            OFS_EV_EN: d.rdata[EV_W-1:0] = q.ev_en;
            default: d.rresp = RESP_SLVERR;
         endcase
      end
      // flags: a new event in the clear cycle survives the clear
      d.pend = (q.pend & ~clr_pend) | src_event; // RULE_14
      d.trap_flag = (q.trap_flag & ~clr_trap) | trap_event; // RULE_16
      ev_set[EV_TRAP] = |trap_event;
      // timed block countdown
      if (link.blk_start) d.blk_cnt = link.blk_len;
      else if (q.blk_cnt != '0) d.blk_cnt = q.blk_cnt - 1'b1;
      // arbitration over traps then users, ascending vector, strict compare
      for (int i = 0; i < NUM_TRAP; i++) begin
         if (q.trap_flag[i] && TRAP_LVL[i] > best_lvl) begin // RULE_17
            found = 1'b1;
            best_lvl = TRAP_LVL[i];
            best_vec = TRAP_VEC[i];
         end
      end
      for (int i = 0; i < NUM_USER; i++) begin
         user_ok = q.pend[i] && q.en[i] && (q.prio[i] != PRIO_OFF); // RULE_01
         if (q.nest_dis && q.sp != '0) user_ok = 1'b0; // RULE_11
         if (q.blk_cnt != '0 && q.prio[i] != PRIO_TOP) user_ok = 1'b0; // RULE_18
         if (user_ok && {1'b0, q.prio[i]} > best_lvl) begin // RULE_19
            found = 1'b1;
            best_lvl = {1'b0, q.prio[i]};
            best_vec = USER_VEC[i];
         end
      end
      d.pend_idx = found ? IDX_W'(best_vec - VEC_BASE) : '0; // RULE_10
      // core handshake: a return wins over an ack in the same cycle
      if (link.ret_req) begin
         ev_set[EV_RETURN] = 1'b1;
         d.ret_valid = 1'b1;
         {d.ret_pc, d.ret_srl, d.level} = '0; // empty stack gives level zero
         if (q.sp != '0) begin
            {d.ret_pc, d.ret_srl, d.level} = q.stack[q.sp - 1'b1]; // RULE_15
            d.sp = q.sp - 1'b1;
         end
      end else if (q.irq_valid && link.irq_ack) begin
         ev_set[EV_TAKEN] = 1'b1;
         d.irq_valid = 1'b0;
         d.level = q.irq_lvl;
         if (q.sp != SP_FULL) begin
            d.stack[q.sp] = {link.ack_pc, link.ack_srl, q.level};
            d.sp = q.sp + 1'b1;
         end
      end else if (!q.irq_valid && found) begin
         // offer is frozen until taken
         d.irq_valid = 1'b1;
         d.irq_vec = best_vec;
         d.irq_lvl = best_lvl;
      end
      // controller events and interrupt output
      d.ev_sts = (q.ev_sts & ~clr_ev) | ev_set;
      d.irq = |(d.ev_sts & d.ev_en);
      d.awready = !d.aw_full && !d.bvalid;
      d.wready = !d.w_full && !d.bvalid;
      d.arready = !d.rvalid;
   end
   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
         q.prio <= {NUM_USER{PRIO_RESET}}; // RULE_02
      end else if (ce) begin
         q <= d;
      end
   end
   assign link.irq_valid = q.irq_valid;
   assign link.irq_vec = q.irq_vec;
   assign link.irq_lvl = q.irq_lvl;
   assign link.ret_valid = q.ret_valid;
   assign link.ret_pc = q.ret_pc;
   assign link.ret_srl = q.ret_srl;
   assign link.cpu_level = q.level;
   assign awready = q.awready;
   assign wready = q.wready;
   assign bresp = q.bresp;
   assign bvalid = q.bvalid;
   assign arready = q.arready;
   assign rdata = q.rdata;
   assign rresp = q.rresp;
   assign rvalid = q.rvalid;
   assign irq = q.irq;
endmodule : intc_ctrl_end
`default_nettype wire

// file: intc_link_checker.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// link checker: ctrl end against core end
// ----------------------------------------
module intc_link_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic irq_valid,
   input wire logic [intc_pkg::VEC_W-1:0] irq_vec,
   input wire logic [intc_pkg::LEVEL_W-1:0] irq_lvl,
   input wire logic irq_ack,
   input wire logic ret_req,
   input wire logic ret_valid,
   input wire logic [intc_pkg::LEVEL_W-1:0] cpu_level
);
   import intc_pkg::*;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // offer frozen until taken
   a_offer_frozen: assert property (irq_valid && !irq_ack |=> irq_valid && $stable({irq_vec, irq_lvl}))
      else $error("offer changed before it was taken");
   // take drops offer, sets level
   a_take_sets_level: assert property (irq_valid && irq_ack && !ret_req |=> !irq_valid && cpu_level == $past(irq_lvl))
      else $error("taken offer did not set the cpu level");
   // offers only above cpu level
   a_offer_above: assert property (irq_valid |-> irq_lvl > cpu_level)
      else $error("offer not above cpu level");
   // traps above level seven
   a_trap_unmasked: assert property (irq_valid && irq_vec < 8'h0d |-> irq_lvl > 4'h7)
      else $error("trap offered at a user level");
   // user levels 1..7
   a_user_range: assert property (irq_valid && irq_vec >= 8'h46 |-> irq_lvl inside {[1:7]})
      else $error("user offer level out of range");
   // a return yields exactly one restore pulse
   a_ret_pulse: assert property (ret_req |=> ret_valid ##1 !ret_valid)
      else $error("restore pulse missing or too long");
   // no restore without a return
   a_ret_caused: assert property ($rose(ret_valid) |-> $past(ret_req))
      else $error("restore without return");
   // return lowers the level
   a_ret_lowers: assert property (ret_req && cpu_level != 4'h0 |=> cpu_level < $past(cpu_level))
      else $error("return did not lower the level");
   // ack answers an offer, one cycle
   a_ack_answers: assert property (irq_ack |-> $past(irq_valid) ##1 !irq_ack)
      else $error("ack without offer or too long");
   c_take: cover property (irq_valid && irq_ack);
   c_trap_take: cover property (irq_valid && irq_ack && irq_vec < 8'h0d);
   c_return: cover property (ret_valid);
endmodule : intc_link_checker
`default_nettype wire

// file: intc_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface intc_link_if;
   import intc_pkg::*;
   logic irq_valid;                // request offered to the core
   logic [VEC_W-1:0] irq_vec;      // its vector number
   logic [LEVEL_W-1:0] irq_lvl;    // its priority level
   logic irq_ack;                  // core takes the request
   logic [PC_W-1:0] ack_pc;        // pc to stack
   logic [SRL_W-1:0] ack_srl;      // status low byte to stack
   logic ret_req;                  // return from interrupt
   logic ret_valid;                // restored context valid
   logic [PC_W-1:0] ret_pc;
   logic [SRL_W-1:0] ret_srl;
   logic blk_start;                // timed interrupt block start
   logic [BLK_W-1:0] blk_len;
   logic [LEVEL_W-1:0] cpu_level;  // current cpu level
   modport ctrl (output irq_valid, irq_vec, irq_lvl, ret_valid, ret_pc, ret_srl, cpu_level,
                 input irq_ack, ack_pc, ack_srl, ret_req, blk_start, blk_len);
   modport core (input irq_valid, irq_vec, irq_lvl, ret_valid, ret_pc, ret_srl, cpu_level,
                 output irq_ack, ack_pc, ack_srl, ret_req, blk_start, blk_len);
endinterface : intc_link_if
`default_nettype wire

// file: intc_pkg.sv
`default_nettype none
package intc_pkg;
   // ----------------------------------------
   // widths
   // ----------------------------------------
   localparam int PRIO_W = 3;   // per-source priority field
   localparam int LEVEL_W = 4;  // cpu priority level 0..15
   localparam int VEC_W = 8;    // full vector number
   localparam int IDX_W = 7;    // vector number minus base
   localparam int PC_W = 24;    // saved program counter
   localparam int SRL_W = 8;    // saved status low byte
   localparam int BLK_W = 14;   // timed block length in cycles
   localparam int ADDR_W = 8;   // axi-lite byte address
   localparam int STACK_W = PC_W + SRL_W + LEVEL_W;
   localparam int NUM_USER = 7; // pwm4, comparator b, adc pairs 0,1,2,3,6
   localparam int NUM_TRAP = 4;
   localparam int EV_W = 3;     // interrupt event bits of the controller
   // ----------------------------------------
   // reset values and encodings
   // ----------------------------------------
   localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h4;
   localparam logic [PRIO_W-1:0] PRIO_OFF = 3'h0;
   localparam logic [PRIO_W-1:0] PRIO_TOP = 3'h7;
   localparam logic [VEC_W-1:0] VEC_BASE = 8'h08;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ----------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [ADDR_W-1:0] OFS_PWM4 = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CMP2 = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_ADC01 = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_ADC23 = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_ADC6 = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_ICON1 = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_PEND = 8'h1c;
   localparam logic [ADDR_W-1:0] OFS_ENABLE = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_EV_STS = 8'h24;
   localparam logic [ADDR_W-1:0] OFS_EV_CLR = 8'h28;
   localparam logic [ADDR_W-1:0] OFS_EV_EN = 8'h2c;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int PWM4_LSB = 4;
   localparam int CMP2_LSB = 12;
   localparam int ADC1_LSB = 12;
   localparam int ADC0_LSB = 8;
   localparam int ADC3_LSB = 4;
   localparam int ADC2_LSB = 0;
   localparam int ADC6_LSB = 0;
   localparam int LEVEL_LSB = 8;
   localparam int NEST_BIT = 15;
   localparam int EV_TAKEN = 0;
   localparam int EV_TRAP = 1;
   localparam int EV_RETURN = 2;
   // user source index: 0 pwm4, 1 cmp b, 2 adc0, 3 adc1, 4 adc2, 5 adc3, 6 adc6
   localparam logic [NUM_USER-1:0][VEC_W-1:0] USER_VEC =
      {8'h4c, 8'h4b, 8'h4a, 8'h49, 8'h48, 8'h47, 8'h46};
   localparam logic [NUM_TRAP-1:0][VEC_W-1:0] TRAP_VEC = {8'h0c, 8'h0b, 8'h0a, 8'h09};
   localparam logic [NUM_TRAP-1:0][LEVEL_W-1:0] TRAP_LVL = {4'hb, 4'hc, 4'hd, 4'he};
endpackage : intc_pkg
`default_nettype wire

// file: test_interrupt_priority_and_status.sv
`timescale 1ns/10ps
`default_nettype none
module test_interrupt_priority_and_status;
   import intc_pkg::*;
   // ----------------------------------------
   // stimulus and observed signals
   // ----------------------------------------
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [6:0] src_event = 7'h0;
   logic [3:0] trap_event = 4'h0;
   logic [7:0] awaddr = 8'h0, araddr = 8'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [3:0] wstrb = 4'h0, s;
   logic awready, wready, bvalid, arready, rvalid, irq, isr_entry, resume_valid;
   logic [1:0] bresp, rresp, r;
   logic accept_en = 1'b0, isr_done = 1'b0, block_cmd = 1'b0;
   logic [PC_W-1:0] cur_pc = 24'h0, resume_pc;
   logic [SRL_W-1:0] cur_srl = 8'h0, resume_srl;
   logic [BLK_W-1:0] block_len = 14'h0;
   logic [VEC_W-1:0] isr_vector;
   logic [LEVEL_W-1:0] isr_level;
   logic [31:0] ctx[$];              // contexts expected back on return
   logic [7:0] ra[5] = '{OFS_PWM4, OFS_CMP2, OFS_ADC01, OFS_ADC23, OFS_ADC6};
   logic [31:0] rm[5] = '{32'h70, 32'h7000, 32'h7700, 32'h77, 32'h7}; // implemented bits
   logic [31:0] pv[5] = '{32'h30, 32'h0, 32'h500, 32'h76, 32'h7}; // setup priorities
   int n_mismatch = 0, checked = 0, n_entry = 0, seen = 0;
   intc_link_if link ();
   always #2 aclk = ~aclk;
   // entries counted mid-cycle, clear of the launching edge
   always @(negedge aclk) if (isr_entry === 1'b1) n_entry <= n_entry + 1;
   intc_ctrl_end #(.DEPTH(16)) intc_ctrl_end_inst (.aclk, .aresetn, .ce(1'b1), .link, .src_event, .trap_event,
      .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .irq);
   cpu_core_end cpu_core_end_inst (.aclk, .aresetn, .ce(1'b1), .link, .accept_en, .cur_pc, .cur_srl, .isr_done,
      .block_cmd, .block_len, .isr_entry, .isr_vector, .isr_level, .resume_valid, .resume_pc, .resume_srl);
   intc_link_checker intc_link_checker_inst (.aclk(aclk), .aresetn(aresetn), .irq_valid(link.irq_valid),
      .irq_vec(link.irq_vec), .irq_lvl(link.irq_lvl), .irq_ack(link.irq_ack), .ret_req(link.ret_req),
      .ret_valid(link.ret_valid), .cpu_level(link.cpu_level));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen_v, input logic [31:0] exp);
      checked++;
      if (seen_v !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen_v);
      end
   endtask : chk
   // a leading edge keeps a release and the next raise apart
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] st);
      logic aw, w, b;
      @(posedge aclk);
      awaddr <= a; wdata <= v; wstrb <= st; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do begin
         // ready sampled mid-cycle, acted on at the next edge
         @(negedge aclk);
         {aw, w, b} = {awready, wready, bvalid};
         @(posedge aclk);
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
      end while (!b);
      bready <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
      logic ar, rv;
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do begin
         @(negedge aclk);
         {ar, rv, v, rr} = {arready, rvalid, rdata, rresp};
         @(posedge aclk);
         if (ar) arvalid <= 1'b0;
      end while (!rv);
      rready <= 1'b0;
   endtask : axi_rd
   task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string nm);
      logic [31:0] v;
      logic [1:0] rr;
      axi_rd(a, v, rr);
      chk(nm, v, exp);
   endtask : rc
   task automatic pulse(input logic [6:0] u, input logic [3:0] t);
      @(posedge aclk);
      src_event <= u; trap_event <= t;
      @(posedge aclk);
      src_event <= 7'h0; trap_event <= 4'h0;
   endtask : pulse
   // waits for the next entry, records the stacked context, then moves pc on
   task automatic wait_entry(input logic [7:0] v, input logic [3:0] l);
      while (n_entry == seen) @(posedge aclk);
      seen++;
      chk("entry", {isr_vector, isr_level}, {v, l});
      ctx.push_back({cur_pc, cur_srl});
      cur_pc <= 24'($urandom);
      cur_srl <= 8'($urandom);
   endtask : wait_entry
   task automatic finish_isr;
      @(posedge aclk);
      isr_done <= 1'b1;
      @(posedge aclk);
      isr_done <= 1'b0;
      do @(negedge aclk); while (resume_valid !== 1'b1);
      chk("resume", {resume_pc, resume_srl}, ctx.pop_back());
   endtask : finish_isr
   task automatic quiet(input int n);
      int e0;
      e0 = n_entry;
      repeat (n) @(posedge aclk);
      chk("entries", n_entry, e0);
   endtask : quiet
   task automatic give_verdict;
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      d = $urandom(32'hd2542497);
      cur_pc <= 24'($urandom);
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (ra[i]) rc(ra[i], rm[i] & 32'h4444, "prio reset");
      rc(OFS_STATUS, 32'h0, "status reset");
      // first pass all ones on all lanes, then random data and lanes
      for (int p = 0; p < 2; p++) foreach (ra[i]) begin
         d = p ? $urandom : 32'hffff_ffff;
         s = p ? 4'($urandom) : 4'hf;
         axi_wr(ra[i], d, s);
         rc(ra[i], ((rm[i] & ~{16'h0, {8{s[1]}}, {8{s[0]}}}) | (d & {16'h0, {8{s[1]}}, {8{s[0]}}})) & rm[i], "prio");
      end
      axi_rd(8'h40, d, r);
      chk("unmapped resp", r, RESP_SLVERR);
      // priorities, then flag clear, then enables
      foreach (ra[i]) axi_wr(ra[i], pv[i], 4'hf);
      axi_wr(OFS_PEND, 32'h7f, 4'hf);
      axi_wr(OFS_ENABLE, 32'h7f, 4'hf);
      axi_wr(OFS_EV_EN, 32'h7, 4'hf);
      pulse(7'h0f, 4'h0);
      rc(OFS_STATUS, 32'h40, "status pending");
      accept_en <= 1'b1;
      wait_entry(8'h48, 4'h5);
      rc(OFS_STATUS, 32'h500, "status level");
      chk("irq set", irq, 1'b1);
      axi_wr(OFS_EV_EN, 32'h0, 4'hf);
      repeat (2) @(posedge aclk);
      chk("irq masked", irq, 1'b0);
      axi_wr(OFS_EV_EN, 32'h7, 4'hf);
      axi_wr(OFS_EV_CLR, 32'h7, 4'hf);
      repeat (2) @(posedge aclk);
      chk("irq cleared", irq, 1'b0);
      finish_isr();
      wait_entry(8'h48, 4'h5);
      axi_wr(OFS_PEND, 32'h4, 4'hf);
      finish_isr();
      wait_entry(8'h46, 4'h3);
      axi_wr(OFS_ICON1, 32'h8000, 4'hf);
      pulse(7'h40, 4'h0);
      quiet(20);
      pulse(7'h0, 4'h1);
      wait_entry(8'h09, 4'he);
      finish_isr();
      wait_entry(8'h09, 4'he);
      axi_wr(OFS_ICON1, 32'h8001, 4'hf);
      finish_isr();
      quiet(20);
      axi_wr(OFS_PEND, 32'h1, 4'hf);
      finish_isr();
      wait_entry(8'h4c, 4'h7);
      axi_wr(OFS_PEND, 32'h40, 4'hf);
      axi_wr(OFS_ICON1, 32'h0, 4'hf);
      finish_isr();
      // timed block: level seven passes, level six waits
      @(posedge aclk);
      block_cmd <= 1'b1;
      block_len <= 14'd300;
      @(posedge aclk);
      block_cmd <= 1'b0;
      pulse(7'h30, 4'h0);
      wait_entry(8'h4b, 4'h7);
      axi_wr(OFS_PEND, 32'h20, 4'hf);
      finish_isr();
      quiet(20);
      wait_entry(8'h4a, 4'h6);
      axi_wr(OFS_PEND, 32'h10, 4'hf);
      finish_isr();
      quiet(30);
      give_verdict();
   end
   // hang guard at 15000 cycles, well past the run's several hundred cycles
   initial begin
      #60000;
      n_mismatch++;
      give_verdict();
   end
endmodule : test_interrupt_priority_and_status
`default_nettype wire
